// ---- rtl/core_cycle_seq.sv ----
// instruction-cycle sequencer, two-stage pipeline and indirect addressing
//
// Contract
// - input clock divided into four phases forming one instruction cycle
// - program counter steps at phase one, starting each fetch cycle
// - next instruction word captured from program memory in phase four
// - fetch and execute overlap, one instruction per cycle
// - fetched word enters instruction register at phase one, executes phases two-four
// - operand read in phase two, result written in phase four
// - program-counter changes take two cycles; fetched word is discarded
// - indirect port holds nothing; access goes to pointer-addressed location
// - indirect read with pointer zero returns 00h
// - indirect write with pointer zero changes no location
// - low five pointer bits select address 00h-1Fh in current bank
// - unbanked: pointer bits seven to five read as ones
// - two banks: pointer bit five picks bank, bits seven-six read ones
// - four banks: pointer bits six-five pick bank, bit seven reads one
// - instruction words are 12 bits, one word fetched per cycle
`timescale 1ns/1ps

module core_cycle_seq
   import core_cycle_pkg::*;
#(
   parameter int PC_W      = 10,
   parameter int BANK_BITS = 1
) (
   // clock and reset
   input  wire logic               core_clk_i,
   input  wire logic               rst_i,
   // phase outputs
   output logic                    phase_one_o,
   output logic                    phase_two_o,
   output logic                    phase_three_o,
   output logic                    phase_four_o,
   // program memory
   output logic [PC_W-1:0]         prog_addr_o,
   input  wire logic [INSTR_W-1:0] prog_data_i,
   // decoder and alu
   output logic [INSTR_W-1:0]      instr_o,
   output logic                    instr_valid_o,
   input  wire logic [FILE_W-1:0]  file_addr_i,
   input  wire logic               rd_req_i,
   input  wire logic               wr_req_i,
   input  wire logic [DATA_W-1:0]  result_i,
   input  wire logic               branch_i,
   input  wire logic [PC_W-1:0]    branch_target_i,
   output logic [DATA_W-1:0]       operand_o,
   output logic [DATA_W-1:0]       pointer_o,
   // data register file
   output logic [ADDR_W-1:0]       data_addr_o,
   output logic                    data_rd_en_o,
   input  wire logic [DATA_W-1:0]  data_rdata_i,
   output logic                    data_wr_en_o,
   output logic [DATA_W-1:0]       data_wdata_o
);

   // ----------------------------------------------------------------
   // configuration masks
   // ----------------------------------------------------------------
   localparam logic [1:0] BANK_MASK = (BANK_BITS >= 2) ? 2'h3 : (BANK_BITS == 1) ? 2'h1 : 2'h0;
   localparam logic [7:0] IMPL_MASK = {1'b0, BANK_MASK, POINTER_LOW_MASK};

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      phase_e               phase;
      logic [PC_W-1:0]      pc;
      logic [INSTR_W-1:0]   fetch_buf;
      logic                 fetch_valid;
      logic [INSTR_W-1:0]   ir;
      logic                 ir_valid;
      logic [DATA_W-1:0]    ptr;
      logic [ADDR_W-1:0]    addr;
      logic                 rd_en;
      logic                 indirect;
      logic                 null_ind;
      logic                 ptr_hit;
      logic [DATA_W-1:0]    operand;
      logic                 wr_en;
      logic                 ptr_wr;
      logic [DATA_W-1:0]    wdata;
   } seq_state_s;

   seq_state_s st_ff;
   seq_state_s nxt_st;
   logic       take_branch;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] ptr_view(input logic [7:0] v);
      ptr_view = v | ~IMPL_MASK;
   endfunction

   function automatic logic [ADDR_W-1:0] resolve(input logic [4:0] fa, input logic [7:0] p);
      logic [4:0] low;
      low = (fa == INDIRECT_PORT_ADDR) ? p[4:0] : fa;
      resolve = {p[6:5] & BANK_MASK, low};
   endfunction

   assign take_branch = st_ff.ir_valid & branch_i;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      case (st_ff.phase)
         PH_ONE: begin
            nxt_st.phase    = PH_TWO;
            nxt_st.addr     = resolve(file_addr_i, st_ff.ptr);
            nxt_st.indirect = (file_addr_i == INDIRECT_PORT_ADDR);
            nxt_st.null_ind = (file_addr_i == INDIRECT_PORT_ADDR) && (st_ff.ptr[4:0] == INDIRECT_PORT_ADDR);
            nxt_st.ptr_hit  = (resolve(file_addr_i, st_ff.ptr) == {2'h0, POINTER_ADDR})
                              || (resolve(file_addr_i, st_ff.ptr) ==
                                  {st_ff.ptr[6:5] & BANK_MASK, POINTER_ADDR});
            nxt_st.rd_en    = st_ff.ir_valid & rd_req_i;
         end
         PH_TWO: begin
            nxt_st.phase = PH_THREE;
            nxt_st.rd_en = 1'b0;
            if (st_ff.rd_en) begin
               if (st_ff.null_ind) begin
                  nxt_st.operand = NULL_READ_VALUE;
               end else if (st_ff.ptr_hit) begin
                  nxt_st.operand = ptr_view(st_ff.ptr);
               end else begin
                  nxt_st.operand = data_rdata_i;
               end
            end
         end
         PH_THREE: begin
            nxt_st.phase       = PH_FOUR;
            nxt_st.fetch_buf   = prog_data_i;
            nxt_st.fetch_valid = 1'b1;
            nxt_st.wdata       = result_i;
            nxt_st.wr_en       = st_ff.ir_valid & wr_req_i & ~st_ff.null_ind & ~st_ff.ptr_hit;
            nxt_st.ptr_wr      = st_ff.ir_valid & wr_req_i & ~st_ff.null_ind & st_ff.ptr_hit;
         end
         PH_FOUR: begin
            nxt_st.phase  = PH_ONE;
            nxt_st.wr_en  = 1'b0;
            nxt_st.ptr_wr = 1'b0;
            if (st_ff.ptr_wr) begin
               nxt_st.ptr = ptr_view(st_ff.wdata);
            end
            nxt_st.ir       = st_ff.fetch_buf;
            nxt_st.ir_valid = st_ff.fetch_valid & ~take_branch;
            if (take_branch) begin
               nxt_st.pc = branch_target_i;
            end else begin
               nxt_st.pc = PC_W'(st_ff.pc + 1'b1);
            end
         end
         default: begin
            nxt_st.phase = PH_ONE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st_ff.phase       <= PH_ONE;
         st_ff.pc          <= PC_RESET_VALUE[PC_W-1:0];
         st_ff.fetch_buf   <= INSTR_RESET;
         st_ff.fetch_valid <= 1'b0;
         st_ff.ir          <= INSTR_RESET;
         st_ff.ir_valid    <= 1'b0;
         st_ff.ptr         <= POINTER_RESET;
         st_ff.addr        <= '0;
         st_ff.rd_en       <= 1'b0;
         st_ff.indirect    <= 1'b0;
         st_ff.null_ind    <= 1'b0;
         st_ff.ptr_hit     <= 1'b0;
         st_ff.operand     <= NULL_READ_VALUE;
         st_ff.wr_en       <= 1'b0;
         st_ff.ptr_wr      <= 1'b0;
         st_ff.wdata       <= NULL_READ_VALUE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign phase_one_o   = (st_ff.phase == PH_ONE);
   assign phase_two_o   = (st_ff.phase == PH_TWO);
   assign phase_three_o = (st_ff.phase == PH_THREE);
   assign phase_four_o  = (st_ff.phase == PH_FOUR);
   assign prog_addr_o   = st_ff.pc;
   assign instr_o       = st_ff.ir;
   assign instr_valid_o = st_ff.ir_valid;
   assign operand_o     = st_ff.operand;
   assign pointer_o     = ptr_view(st_ff.ptr);
   assign data_addr_o   = st_ff.addr;
   assign data_rd_en_o  = st_ff.rd_en & ~st_ff.null_ind & ~st_ff.ptr_hit;
   assign data_wr_en_o  = st_ff.wr_en;
   assign data_wdata_o  = st_ff.wdata;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   chk_phase_order: assert property (
      phase_one_o |=> phase_two_o ##1 phase_three_o ##1 phase_four_o ##1 phase_one_o)
      else $error("phase sequence broken");

   chk_pc_step: assert property (
      (phase_four_o && !take_branch) |=> (prog_addr_o == PC_W'($past(prog_addr_o) + 1'b1)) && phase_one_o)
      else $error("pc did not step at phase one");

   chk_fetch_capture: assert property (
      phase_three_o |=> (st_ff.fetch_buf == $past(prog_data_i)) && phase_four_o)
      else $error("fetch word not captured");

   chk_ir_load: assert property (
      phase_four_o |=> (instr_o == $past(st_ff.fetch_buf)) ##3 (instr_o == $past(instr_o, 3)))
      else $error("instruction register load wrong");

   chk_access_phase: assert property (
      (data_rd_en_o |-> phase_two_o) and (data_wr_en_o |-> phase_four_o))
      else $error("data access outside its phase");

   chk_branch_flush: assert property (
      (phase_four_o && take_branch) |=>
         (prog_addr_o == $past(branch_target_i)) && !instr_valid_o ##4 instr_valid_o)
      else $error("branch did not flush and refetch");

   chk_null_read: assert property (
      (phase_two_o && st_ff.rd_en && st_ff.null_ind) |=> (operand_o == NULL_READ_VALUE))
      else $error("null indirect read not zero");

   chk_null_write: assert property (
      (phase_three_o && st_ff.null_ind) |=> !data_wr_en_o && !st_ff.ptr_wr)
      else $error("null indirect write took effect");

   chk_indirect_addr: assert property (
      (phase_one_o && file_addr_i == INDIRECT_PORT_ADDR) |=> (data_addr_o[4:0] == $past(st_ff.ptr[4:0])))
      else $error("indirect address not from pointer");

   chk_ptr_fill: assert property (
      (pointer_o | IMPL_MASK) == 8'hFF)
      else $error("unimplemented pointer bits not ones");

   chk_ptr_write: assert property (
      (phase_four_o && st_ff.ptr_wr) |=> ((pointer_o & IMPL_MASK) == ($past(data_wdata_o) & IMPL_MASK)))
      else $error("pointer write did not land");

   chk_bank_mask: assert property (
      phase_two_o |-> ((data_addr_o[6:5] & ~BANK_MASK) == 2'h0))
      else $error("bank bit outside configuration");

   chk_bank_select: assert property (
      phase_two_o |-> (data_addr_o[6:5] == (pointer_o[6:5] & BANK_MASK)))
      else $error("bank not taken from pointer");

   chk_ptr_read: assert property (
      (phase_two_o && st_ff.rd_en && st_ff.ptr_hit) |=> (operand_o == pointer_o))
      else $error("pointer read not served");

   chk_data_read: assert property (
      data_rd_en_o |=> (operand_o == $past(data_rdata_i)))
      else $error("operand not taken from data file");

   chk_write_data: assert property (
      data_wr_en_o |-> (data_wdata_o == $past(result_i)))
      else $error("write data not the result");

   chk_flush_quiet: assert property (
      !instr_valid_o |-> (!data_rd_en_o && !data_wr_en_o && !st_ff.ptr_wr))
      else $error("flushed slot touched data");

   chk_pc_hold: assert property (
      !phase_four_o |=> $stable(prog_addr_o))
      else $error("pc moved outside phase one entry");

   chk_fetch_once: assert property (
      !phase_three_o |=> $stable(st_ff.fetch_buf))
      else $error("fetch word taken outside phase four");

   chk_valid_steady: assert property (
      (phase_four_o && instr_valid_o && !take_branch) |=> instr_valid_o)
      else $error("pipeline lost an instruction");

   chk_ptr_stable: assert property (
      !(phase_four_o && st_ff.ptr_wr) |=> $stable(pointer_o))
      else $error("pointer changed without a write");

   cov_branch: cover property (phase_four_o && take_branch);
   cov_null_read: cover property (phase_two_o && st_ff.rd_en && st_ff.null_ind);
   cov_ptr_write: cover property (phase_four_o && st_ff.ptr_wr);
   cov_data_write: cover property (data_wr_en_o && st_ff.indirect);
   cov_ptr_read: cover property (phase_two_o && st_ff.rd_en && st_ff.ptr_hit);

endmodule // core_cycle_seq

// ---- rtl/core_cycle_pkg.sv ----
// shared constants and types for the instruction-cycle sequencer
package core_cycle_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int INSTR_W = 12;
   localparam int DATA_W  = 8;
   localparam int FILE_W  = 5;
   localparam int ADDR_W  = 7;

   // ----------------------------------------------------------------
   // data-file map and values
   // ----------------------------------------------------------------
   localparam logic [4:0] INDIRECT_PORT_ADDR = 5'h00;
   localparam logic [4:0] POINTER_ADDR       = 5'h04;
   localparam logic [7:0] NULL_READ_VALUE    = 8'h00;
   localparam logic [7:0] POINTER_RESET      = 8'hFF;
   localparam logic [4:0] POINTER_LOW_MASK   = 5'h1F;

   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [11:0] PC_RESET_VALUE  = 12'h000;
   localparam logic [11:0] INSTR_RESET     = 12'h000;
   localparam int          PHASES_PER_CYCLE = 4;

   // ----------------------------------------------------------------
   // phase states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PH_ONE   = 2'b00,
      PH_TWO   = 2'b01,
      PH_THREE = 2'b10,
      PH_FOUR  = 2'b11
   } phase_e;

endpackage

// ---- testbench/core_mem_model.sv ----
// partner model: program memory and data register file
`timescale 1ns/1ps

module core_mem_model
   import core_cycle_pkg::*;
#(
   parameter int PC_W = 10
) (
   // clock
   input  wire logic              core_clk_i,
   // program memory
   input  wire logic [PC_W-1:0]   prog_addr_i,
   output logic [INSTR_W-1:0]     prog_data_o,
   // data register file
   input  wire logic [ADDR_W-1:0] data_addr_i,
   input  wire logic              data_rd_en_i,
   output logic [DATA_W-1:0]      data_rdata_o,
   input  wire logic              data_wr_en_i,
   input  wire logic [DATA_W-1:0] data_wdata_i
);
   logic [DATA_W-1:0] mem [0:127];
   logic [DATA_W-1:0] last;

   // ------------------------------------------------------------
   // read paths; unselected data bus shows inverse of last value
   // ------------------------------------------------------------
   assign prog_data_o  = 12'hC00 ^ INSTR_W'(prog_addr_i);
   assign data_rdata_o = data_rd_en_i ? mem[data_addr_i] : ~last;

   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'hA5 ^ 8'(i);
      end
      last = 8'h00;
   end

   always @(posedge core_clk_i) begin
      if (data_rd_en_i) begin
         last <= mem[data_addr_i];
      end
      if (data_wr_en_i) begin
         mem[data_addr_i] <= data_wdata_i;
      end
   end
endmodule // core_mem_model

// ---- testbench/core_cycle_and_indirect_addressing_bench.sv ----
// self-checking bench for the instruction-cycle sequencer
`timescale 1ns/1ps

module core_cycle_and_indirect_addressing_bench import core_cycle_pkg::*;;
   localparam int PC_W = 10;
   logic core_clk_i = 1'b0;
   logic rst_i, phase_one_o, phase_two_o, phase_three_o, phase_four_o, instr_valid_o, rd_req_i, wr_req_i;
   logic branch_i, data_rd_en_o, data_wr_en_o;
   logic [PC_W-1:0] prog_addr_o, branch_target_i, exp_pc, last_pc;
   logic [11:0] prog_data_i, instr_o;
   logic [4:0]  file_addr_i;
   logic [7:0]  result_i, operand_o, pointer_o, data_rdata_i, data_wdata_o, exp_ptr;
   logic [6:0]  data_addr_o;
   logic [7:0]  shadow [0:127];
   logic [31:0] seed = 32'd14;
   logic        vld;
   int          n_errors = 0;
   int          n_checks = 0;

   always #25 core_clk_i = ~core_clk_i;

   core_cycle_seq #(.PC_W(PC_W), .BANK_BITS(1)) core_cycle_seq_inst (.core_clk_i, .rst_i, .phase_one_o,
      .phase_two_o, .phase_three_o, .phase_four_o, .prog_addr_o, .prog_data_i, .instr_o, .instr_valid_o,
      .file_addr_i, .rd_req_i, .wr_req_i, .result_i, .branch_i, .branch_target_i, .operand_o, .pointer_o,
      .data_addr_o, .data_rd_en_o, .data_rdata_i, .data_wr_en_o, .data_wdata_o);

   core_mem_model #(.PC_W(PC_W)) core_mem_model_inst (.core_clk_i, .prog_addr_i(prog_addr_o),
      .prog_data_o(prog_data_i), .data_addr_i(data_addr_o), .data_rd_en_i(data_rd_en_o),
      .data_rdata_o(data_rdata_i), .data_wr_en_i(data_wr_en_o), .data_wdata_i(data_wdata_o));

   // ------------------------------------------------------------
   // unbanked and four-bank copies on the same stimulus
   // ------------------------------------------------------------
   for (genvar b = 0; b <= 2; b += 2) begin : g_cfg
      logic [7:0] ptr;
      logic [6:0] addr;
      core_cycle_seq #(.PC_W(PC_W), .BANK_BITS(b)) core_cycle_seq_inst (.core_clk_i, .rst_i, .phase_one_o(),
         .phase_two_o(), .phase_three_o(), .phase_four_o(), .prog_addr_o(), .prog_data_i, .instr_o(),
         .instr_valid_o(), .file_addr_i, .rd_req_i, .wr_req_i, .result_i, .branch_i, .branch_target_i,
         .operand_o(), .pointer_o(ptr), .data_addr_o(addr), .data_rd_en_o(), .data_rdata_i,
         .data_wr_en_o(), .data_wdata_o());
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // one instruction cycle, entered at the falling edge inside phase one
   task automatic cyc(input logic [4:0] fa, input logic rd, input logic wr, input logic [7:0] res,
                      input logic br, input logic [PC_W-1:0] tgt);
      logic [6:0] ea;
      logic       nul;
      logic       prf;
      ea  = {1'b0, exp_ptr[5], (fa == INDIRECT_PORT_ADDR) ? exp_ptr[4:0] : fa};
      nul = (fa == INDIRECT_PORT_ADDR) && (exp_ptr[4:0] == 5'h00);
      prf = (ea[4:0] == POINTER_ADDR);
      check("pc", 16'(prog_addr_o), 16'(exp_pc));
      check("valid", 16'(instr_valid_o), 16'(vld));
      if (vld) begin
         check("instr", 16'(instr_o), 16'(12'hC00 ^ 12'(last_pc)));
      end
      check("pointer", 16'(pointer_o), 16'(exp_ptr | 8'hC0));
      check("pointer flat", 16'(g_cfg[0].ptr), 16'(exp_ptr | 8'hE0));
      check("pointer quad", 16'(g_cfg[2].ptr), 16'(exp_ptr | 8'h80));
      file_addr_i = fa;
      rd_req_i = rd;
      for (int k = 0; k < 4; k++) begin
         check("phase", 16'({phase_one_o, phase_two_o, phase_three_o, phase_four_o}), 16'(4'b1000 >> k));
         if (k == 1) begin
            check("rd_en", 16'(data_rd_en_o), 16'(rd && !nul && !prf));
            check("addr flat", 16'(g_cfg[0].addr), 16'({2'b00, ea[4:0]}));
            check("addr quad", 16'(g_cfg[2].addr), 16'({exp_ptr[6:5], ea[4:0]}));
            if (rd && !nul && !prf) check("rd_addr", 16'(data_addr_o), 16'(ea));
         end
         if (k == 2) begin
            if (rd) check("operand", 16'(operand_o), 16'(nul ? NULL_READ_VALUE : prf ? exp_ptr | 8'hC0 : shadow[ea]));
            wr_req_i = wr;
            result_i = res;
         end
         if (k == 3) begin
            check("wr_en", 16'(data_wr_en_o), 16'(wr && !nul && !prf));
            if (wr && !nul && !prf) check("wr_addr", 16'({data_addr_o, data_wdata_o}), 16'({ea, res}));
            branch_i = br;
            branch_target_i = tgt;
         end
         @(negedge core_clk_i);
      end
      if (wr && !nul && prf) exp_ptr = res;
      if (wr && !nul && !prf) shadow[ea] = res;
      last_pc = exp_pc;
      exp_pc = (br && vld) ? tgt : exp_pc + 1'b1;
      vld = !(br && vld);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] r;
      for (int i = 0; i < 128; i++) shadow[i] = 8'hA5 ^ 8'(i);
      {rst_i, rd_req_i, wr_req_i, branch_i, file_addr_i, result_i, branch_target_i} = '0;
      rst_i = 1'b1;
      repeat (16) @(negedge core_clk_i);
      check("reset pointer", 16'(pointer_o), 16'(POINTER_RESET));
      rst_i = 1'b0;
      {exp_pc, last_pc, vld, exp_ptr} = {PC_RESET_VALUE[PC_W-1:0], PC_RESET_VALUE[PC_W-1:0], 1'b0, POINTER_RESET};
      cyc(5'h00, 1'b0, 1'b0, 8'h00, 1'b1, 10'h155);
      cyc(POINTER_ADDR, 1'b0, 1'b1, 8'h00, 1'b0, 10'h000);
      cyc(5'h00, 1'b1, 1'b1, 8'h77, 1'b0, 10'h000);
      cyc(POINTER_ADDR, 1'b1, 1'b1, 8'h2A, 1'b0, 10'h000);
      cyc(5'h00, 1'b1, 1'b1, 8'h3C, 1'b0, 10'h000);
      cyc(5'h0A, 1'b1, 1'b0, 8'h00, 1'b1, 10'h3FF);
      for (int n = 0; n < 80; n++) begin
         r = rnd();
         if (!vld) cyc(5'h00, 1'b0, 1'b0, 8'h00, r[0], r[9:0]);
         else if (r[13:12] == 2'd0) cyc(POINTER_ADDR, r[1], 1'b1, r[23:16], 1'b0, 10'h000);
         else if (r[13:12] == 2'd1) cyc(5'h00, r[1], r[2], r[23:16], 1'b0, 10'h000);
         else if (r[13:12] == 2'd2) cyc(r[28:24], r[1], r[2], r[23:16], 1'b0, 10'h000);
         else cyc(r[28:24], r[1], 1'b0, 8'h00, 1'b1, r[9:0]);
      end
      conclude();
   end

   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_errors++;
      conclude();
   end
endmodule // core_cycle_and_indirect_addressing_bench
